/* File: design/pmis_core.sv */
`timescale 1ns/1ns
// Notes on behaviour
// RULE1: full preclear pair zeroes watchdog, clears timeout and power-down.
// RULE2: one preclear half alone only sets its indicator.
// RULE3: memory complement inverts byte, writes back, updates zero only.
// RULE4: complement to accumulator, byte untouched, zero flag only.
// RULE5: adjust low nibble by six when above nine or half carry set.
// RULE6: carry of low fix into high nibble; high fix sets carry.
// RULE7: decimal adjust writes memory; only carry may change.
// RULE8: inc/dec byte, result to byte or accumulator, zero updated.
// RULE9: power-down stops execution; memory and registers kept.
// RULE10: halt zeroes watchdog, prescaler, timeout, sets power-down, pc+1.
// RULE11: direct jump loads program counter from instruction, flags untouched.
// RULE12: moves copy immediate or byte to accumulator, or accumulator to byte.
// RULE13: no-operation only advances program counter.
// RULE14: or with immediate or byte, to accumulator or byte, zero only.
// RULE15: subroutine return restores pc from stack in two cycles.
// RULE16: return with value restores pc and loads immediate into accumulator.
// RULE17: interrupt return restores pc and sets master interrupt enable.
// RULE18: memory left rotate, bit seven into bit zero, written back.
// RULE19: left rotate to accumulator, byte and flags untouched.
// RULE20: writing the pc low byte costs one extra instruction cycle.
// RULE21: single watchdog clear zeroes counter, timeout and power-down flags.
// RULE22: completed preclear pair resets both indicators.
// RULE23: zero flag set on all-zero result, else cleared.
module pmis_core
	import pmis_pkg::*;
#(
	parameter logic [DATA_W-1:0] PCL_ADDR = 8'h06
)(
	input  wire logic               mclk,
	input  wire logic               reset_n,
	input  wire logic               reqValid,
	input  wire pmis_req_t          req,
	input  wire logic [PC_W-1:0]    stackTop,
	input  wire logic               wakeReq,
	input  wire logic               emiClear,
	input  wire logic               statusWrEn,
	input  wire pmis_flags_t        statusWrData,
	output logic                    reqReady_r,
	output logic                    doneStrobe_r,
	output logic                    memWrEn_r,
	output logic [DATA_W-1:0]       memWrAddr_r,
	output logic [DATA_W-1:0]       memWrData_r,
	output logic                    stackPop_r,
	output logic [PC_W-1:0]         pc_r,
	output logic [DATA_W-1:0]       acc_r,
	output pmis_flags_t             flags_r,
	output logic                    emi_r,
	output logic                    halted_r,
	output logic [WDT_W-1:0]        wdtCount_r,
	output logic                    timeoutFlag_r,
	output logic                    powerdownFlag_r
);

	// decoding shared by timing and datapath
	function automatic logic writesMem(input pmis_op_t op);
		writesMem = (op == OP_COMPLEMENT_MEM) || (op == OP_DECIMAL_ADJUST)
			|| (op == OP_INCREMENT_MEM) || (op == OP_DECREMENT_MEM)
			|| (op == OP_MOVE_ACC_TO_MEM) || (op == OP_OR_TO_MEMORY)
			|| (op == OP_ROTATE_LEFT_MEM);
	endfunction : writesMem

	function automatic logic isReturn(input pmis_op_t op);
		isReturn = (op == OP_RETURN_SUBROUTINE)
			|| (op == OP_RETURN_WITH_VALUE)
			|| (op == OP_RETURN_FROM_INT);
	endfunction : isReturn

	// clocks for one instruction, minus one
	function automatic logic [CYC_CNT_W-1:0] clocksFor(input pmis_req_t r);
		int cycles;
		cycles = (isReturn(r.op) || r.op == OP_JUMP_DIRECT) ?
			CYC_LONG : CYC_SHORT; // [RULE15]
		if (writesMem(r.op) && r.dataAddr == PCL_ADDR)
			cycles = cycles + 1; // [RULE20]
		clocksFor = CYC_CNT_W'(cycles * CLKS_PER_CYC - 1);
	endfunction : clocksFor

	// bcd correction: {carry, result}
	function automatic logic [DATA_W:0] bcdAdjust(
		input logic [DATA_W-1:0] a,
		input logic              ac,
		input logic              c
	);
		logic [4:0] lo;
		logic [4:0] hi;
		logic       cOut;
		lo = {1'b0, a[3:0]};
		if (a[3:0] > BCD_LIMIT || ac)
			lo = 5'(lo + BCD_FIX); // [RULE5]
		hi = 5'({1'b0, a[7:4]} + {4'h0, lo[4]}); // [RULE6]
		cOut = c;
		if (hi > {1'b0, BCD_LIMIT} || c) begin
			hi   = 5'(hi + BCD_FIX); // [RULE6]
			cOut = 1'b1;
		end
		bcdAdjust = {cOut, hi[3:0], lo[3:0]};
	endfunction : bcdAdjust

	function automatic logic [DATA_W-1:0] rotl(input logic [DATA_W-1:0] d);
		rotl = {d[DATA_W-2:0], d[DATA_W-1]}; // [RULE18] [RULE19]
	endfunction : rotl

	logic                 busy_r;
	logic [CYC_CNT_W-1:0] cnt_r;
	pmis_req_t            cur_r;
	logic                 preFirst_r;
	logic                 preSecond_r;

	logic                 accept;
	logic                 execNow;
	logic                 isPreFirst;
	logic                 isPreSecond;
	logic                 pairNow;
	logic                 wdtClear;
	logic                 enterHalt;
	logic                 pclWrite;
	logic [DATA_W:0]      daaOut;
	logic [PC_W-1:0]      pcInc;

	logic [DATA_W-1:0]    result;
	logic                 toMem;
	logic                 toAcc;
	logic                 zeroUpd;
	logic                 carryUpd;

	logic [PC_W-1:0]      pc_nxt;
	pmis_flags_t          flags_nxt;
	logic [DATA_W-1:0]    acc_nxt;
	logic                 emi_nxt;
	logic                 ready_nxt;
	logic                 halted_nxt;

	// handshake and sequencing decode
	assign accept      = reqValid & reqReady_r;
	assign execNow     = busy_r & (cnt_r == '0);
	assign isPreFirst  = cur_r.op == OP_WDOG_PRECLR_FIRST;
	assign isPreSecond = cur_r.op == OP_WDOG_PRECLR_SECOND;
	assign pairNow     = (isPreFirst & preSecond_r)
		| (isPreSecond & preFirst_r); // [RULE1]
	assign wdtClear    = execNow & (pairNow
		| cur_r.op == OP_WDOG_CLEAR_SINGLE); // [RULE1] [RULE21]
	assign enterHalt   = execNow & (cur_r.op == OP_POWER_DOWN); // [RULE10]
	assign pclWrite    = writesMem(cur_r.op) && cur_r.dataAddr == PCL_ADDR;
	assign daaOut      = bcdAdjust(acc_r, flags_r.halfCarry, flags_r.carry);
	assign pcInc       = PC_W'(pc_r + PC_STEP);

	// per-instruction result and destination
	always_comb begin
		result   = ZERO_VAL;
		toMem    = 1'b0;
		toAcc    = 1'b0;
		zeroUpd  = 1'b0;
		carryUpd = 1'b0;
		unique case (cur_r.op)
			OP_COMPLEMENT_MEM: begin
				result  = ~cur_r.dataByte; // [RULE3]
				toMem   = 1'b1;
				zeroUpd = 1'b1;
			end
			OP_COMPLEMENT_TO_ACC: begin
				result  = ~cur_r.dataByte; // [RULE4]
				toAcc   = 1'b1;
				zeroUpd = 1'b1;
			end
			OP_DECIMAL_ADJUST: begin
				result   = daaOut[DATA_W-1:0]; // [RULE7]
				toMem    = 1'b1;
				carryUpd = 1'b1;
			end
			OP_INCREMENT_MEM, OP_INCREMENT_TO_ACC: begin
				result  = DATA_W'(cur_r.dataByte + ONE_VAL); // [RULE8]
				toMem   = cur_r.op == OP_INCREMENT_MEM;
				toAcc   = cur_r.op == OP_INCREMENT_TO_ACC;
				zeroUpd = 1'b1;
			end
			OP_DECREMENT_MEM, OP_DECREMENT_TO_ACC: begin
				result  = DATA_W'(cur_r.dataByte - ONE_VAL); // [RULE8]
				toMem   = cur_r.op == OP_DECREMENT_MEM;
				toAcc   = cur_r.op == OP_DECREMENT_TO_ACC;
				zeroUpd = 1'b1;
			end
			OP_MOVE_MEM_TO_ACC: begin
				result = cur_r.dataByte; // [RULE12]
				toAcc  = 1'b1;
			end
			OP_MOVE_IMM_TO_ACC, OP_RETURN_WITH_VALUE: begin
				result = cur_r.imm; // [RULE12] [RULE16]
				toAcc  = 1'b1;
			end
			OP_MOVE_ACC_TO_MEM: begin
				result = acc_r; // [RULE12]
				toMem  = 1'b1;
			end
			OP_OR_MEM_TO_ACC, OP_OR_TO_MEMORY: begin
				result  = acc_r | cur_r.dataByte; // [RULE14]
				toMem   = cur_r.op == OP_OR_TO_MEMORY;
				toAcc   = cur_r.op == OP_OR_MEM_TO_ACC;
				zeroUpd = 1'b1;
			end
			OP_OR_IMM_TO_ACC: begin
				result  = acc_r | cur_r.imm; // [RULE14]
				toAcc   = 1'b1;
				zeroUpd = 1'b1;
			end
			OP_ROTATE_LEFT_MEM: begin
				result = rotl(cur_r.dataByte); // [RULE18]
				toMem  = 1'b1;
			end
			OP_ROTATE_LEFT_TO_ACC: begin
				result = rotl(cur_r.dataByte); // [RULE19]
				toAcc  = 1'b1;
			end
			OP_NO_OPERATION, OP_WDOG_CLEAR_SINGLE, OP_WDOG_PRECLR_FIRST,
			OP_WDOG_PRECLR_SECOND, OP_POWER_DOWN, OP_JUMP_DIRECT,
			OP_RETURN_SUBROUTINE, OP_RETURN_FROM_INT: begin
				result = ZERO_VAL; // [RULE13]
			end
			default: begin
				result = ZERO_VAL;
			end
		endcase
	end

	// program counter: jump, return, low-byte load, else step by one
	assign pc_nxt = !execNow ? pc_r :
		(cur_r.op == OP_JUMP_DIRECT) ? cur_r.jumpAddr : // [RULE11]
		isReturn(cur_r.op) ? stackTop : // [RULE15] [RULE16] [RULE17]
		pclWrite ? {pcInc[PC_W-1:DATA_W], result} : pcInc; // [RULE10]

	// flags: execution wins over the external preset in the same cycle
	always_comb begin
		flags_nxt = flags_r;
		if (execNow) begin
			if (zeroUpd)
				flags_nxt.zero = (result == ZERO_VAL); // [RULE23]
			if (carryUpd)
				flags_nxt.carry = daaOut[DATA_W]; // [RULE6] [RULE7]
		end else if (statusWrEn) begin
			flags_nxt = statusWrData;
		end
	end

	assign acc_nxt = (execNow & toAcc) ? result : acc_r;
	// interrupt return setting wins over a clear in the same cycle
	assign emi_nxt = (execNow & cur_r.op == OP_RETURN_FROM_INT) ? 1'b1 :
		emiClear ? 1'b0 : emi_r; // [RULE17]

	// halt holds off new requests until wake; state is kept meanwhile
	assign halted_nxt = enterHalt ? 1'b1 :
		wakeReq ? 1'b0 : halted_r; // [RULE9]
	assign ready_nxt = accept ? 1'b0 :
		execNow ? !enterHalt :
		(halted_r & wakeReq) ? 1'b1 : reqReady_r; // [RULE9]

	// sequencer: latch request, count down the instruction clocks
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			busy_r <= 1'b0;
			cnt_r  <= '0;
			cur_r  <= '0;
		end else if (accept) begin
			busy_r <= 1'b1;
			cnt_r  <= clocksFor(req); // [RULE15] [RULE20]
			cur_r  <= req;
		end else if (execNow) begin
			busy_r <= 1'b0;
		end else if (busy_r) begin
			cnt_r <= cnt_r - 1'b1;
		end
	end

	// preclear indicators
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			preFirst_r  <= 1'b0;
			preSecond_r <= 1'b0;
		end else if (execNow & pairNow) begin
			preFirst_r  <= 1'b0; // [RULE22]
			preSecond_r <= 1'b0;
		end else if (execNow) begin
			preFirst_r  <= preFirst_r | isPreFirst; // [RULE2]
			preSecond_r <= preSecond_r | isPreSecond;
		end
	end

	// architectural state and strobes
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			reqReady_r   <= 1'b1;
			doneStrobe_r <= 1'b0;
			memWrEn_r    <= 1'b0;
			memWrAddr_r  <= ZERO_VAL;
			memWrData_r  <= ZERO_VAL;
			stackPop_r   <= 1'b0;
			pc_r         <= PC_RST_VAL;
			acc_r        <= ACC_RST_VAL;
			flags_r      <= '0;
			emi_r        <= 1'b0;
			halted_r     <= 1'b0;
		end else begin
			reqReady_r   <= ready_nxt;
			doneStrobe_r <= execNow;
			memWrEn_r    <= execNow & toMem;
			memWrAddr_r  <= execNow ? cur_r.dataAddr : memWrAddr_r;
			memWrData_r  <= execNow ? result : memWrData_r;
			stackPop_r   <= execNow & isReturn(cur_r.op);
			pc_r         <= pc_nxt;
			acc_r        <= acc_nxt;
			flags_r      <= flags_nxt;
			emi_r        <= emi_nxt;
			halted_r     <= halted_nxt;
		end
	end

	// watchdog counter, prescaler and its two flags
	pmis_watchdog u_watchdog (
		.mclk        (mclk),
		.reset_n     (reset_n),
		.clearAll    (wdtClear),
		.enterHalt   (enterHalt),
		.count_r     (wdtCount_r),
		.timeout_r   (timeoutFlag_r),
		.powerdown_r (powerdownFlag_r)
	);

	// checks of the execution semantics
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	AST_PAIR_CLEAR: assert property ( // [RULE1]
		execNow && pairNow |=> wdtCount_r == WDT_CLEAR_VAL
			&& !powerdownFlag_r && !preFirst_r && !preSecond_r)
		else $error("preclear pair did not clear watchdog");
	AST_SINGLE_PRE: assert property ( // [RULE2]
		execNow && isPreFirst && !pairNow |=> preFirst_r
			&& powerdownFlag_r == $past(powerdownFlag_r))
		else $error("lone preclear changed flags");
	AST_COMPLEMENT: assert property ( // [RULE3]
		execNow && cur_r.op == OP_COMPLEMENT_MEM |=> memWrEn_r
			&& memWrData_r == ~$past(cur_r.dataByte)
			&& flags_r.carry == $past(flags_r.carry))
		else $error("memory complement wrong");
	AST_DAA_DEST: assert property ( // [RULE7]
		execNow && cur_r.op == OP_DECIMAL_ADJUST |=> memWrEn_r
			&& acc_r == $past(acc_r) && flags_r.zero == $past(flags_r.zero))
		else $error("decimal adjust touched accumulator or zero");
	AST_HALT_ENTRY: assert property ( // [RULE10]
		enterHalt |=> powerdownFlag_r && halted_r && !reqReady_r
			&& pc_r == PC_W'($past(pc_r) + PC_STEP))
		else $error("power-down entry wrong");
	AST_RET_TIME: assert property ( // [RULE15]
		accept && req.op == OP_RETURN_SUBROUTINE
			|=> !doneStrobe_r [*8] ##1 (doneStrobe_r && stackPop_r))
		else $error("return did not take two cycles");
	AST_PCL_EXTRA: assert property ( // [RULE20]
		accept && req.op == OP_MOVE_ACC_TO_MEM && req.dataAddr == PCL_ADDR
			|=> !doneStrobe_r [*8] ##1 doneStrobe_r)
		else $error("pc low byte write lacks extra cycle");
	AST_RETURN_FROM_INTERRUPT_EMI: assert property ( // [RULE17]
		execNow && cur_r.op == OP_RETURN_FROM_INT |=> emi_r
			&& pc_r == $past(stackTop))
		else $error("interrupt return did not enable");
	AST_ROTATE: assert property ( // [RULE18]
		execNow && cur_r.op == OP_ROTATE_LEFT_MEM |=> memWrEn_r
			&& memWrData_r == rotl($past(cur_r.dataByte))
			&& flags_r == $past(flags_r))
		else $error("left rotate wrong");
	AST_NOP_PC: assert property ( // [RULE13]
		execNow && cur_r.op == OP_NO_OPERATION |=> !memWrEn_r
			&& pc_r == PC_W'($past(pc_r) + PC_STEP) && acc_r == $past(acc_r))
		else $error("no-operation changed state");
	AST_ZERO_FLAG: assert property ( // [RULE23]
		execNow && zeroUpd |=> flags_r.zero == ($past(result) == ZERO_VAL))
		else $error("zero flag mismatch");

	COV_PAIR: cover property (execNow && pairNow);
	COV_DAA_CARRY: cover property (execNow && carryUpd && daaOut[DATA_W]);
	COV_HALT_WAKE: cover property (halted_r ##[1:20] reqReady_r);
	COV_RETURN_FROM_INTERRUPT: cover property (execNow && cur_r.op == OP_RETURN_FROM_INT);

endmodule : pmis_core

/* File: design/pmis_pkg.sv */
package pmis_pkg;

	// datapath and program counter widths
	localparam int DATA_W       = 8;
	localparam int PC_W         = 12;
	localparam int CYC_CNT_W    = 4;
	localparam int WDT_W        = 8;
	localparam int PRESC_W      = 8;

	// one instruction cycle is four system clocks
	localparam int CLKS_PER_CYC = 4;
	localparam int CYC_SHORT    = 1;
	localparam int CYC_LONG     = 2;

	// reset and clear values
	localparam logic [WDT_W-1:0]   WDT_CLEAR_VAL = 8'h00;
	localparam logic [PRESC_W-1:0] PRESC_CLR_VAL = 8'h00;
	localparam logic [DATA_W-1:0]  ACC_RST_VAL   = 8'h00;
	localparam logic [DATA_W-1:0]  ONE_VAL       = 8'h01;
	localparam logic [DATA_W-1:0]  ZERO_VAL      = 8'h00;
	localparam logic [PC_W-1:0]    PC_RST_VAL    = 12'h000;
	localparam logic [PC_W-1:0]    PC_STEP       = 12'h001;

	// decimal adjust figures
	localparam logic [3:0] BCD_LIMIT = 4'h9;
	localparam logic [4:0] BCD_FIX   = 5'h06;

	// decoded instruction codes
	typedef enum logic [4:0] {
		OP_NO_OPERATION       = 5'h00,
		OP_WDOG_CLEAR_SINGLE  = 5'h01,
		OP_WDOG_PRECLR_FIRST  = 5'h02,
		OP_WDOG_PRECLR_SECOND = 5'h03,
		OP_COMPLEMENT_MEM     = 5'h04,
		OP_COMPLEMENT_TO_ACC  = 5'h05,
		OP_DECIMAL_ADJUST     = 5'h06,
		OP_INCREMENT_MEM      = 5'h07,
		OP_INCREMENT_TO_ACC   = 5'h08,
		OP_DECREMENT_MEM      = 5'h09,
		OP_DECREMENT_TO_ACC   = 5'h0a,
		OP_POWER_DOWN         = 5'h0b,
		OP_JUMP_DIRECT        = 5'h0c,
		OP_MOVE_MEM_TO_ACC    = 5'h0d,
		OP_MOVE_IMM_TO_ACC    = 5'h0e,
		OP_MOVE_ACC_TO_MEM    = 5'h0f,
		OP_OR_MEM_TO_ACC      = 5'h10,
		OP_OR_IMM_TO_ACC      = 5'h11,
		OP_OR_TO_MEMORY       = 5'h12,
		OP_RETURN_SUBROUTINE  = 5'h13,
		OP_RETURN_WITH_VALUE  = 5'h14,
		OP_RETURN_FROM_INT    = 5'h15,
		OP_ROTATE_LEFT_MEM    = 5'h16,
		OP_ROTATE_LEFT_TO_ACC = 5'h17
	} pmis_op_t;

	// one decoded instruction with its operand byte already read
	typedef struct packed {
		pmis_op_t            op;
		logic [DATA_W-1:0]   dataAddr;
		logic [DATA_W-1:0]   dataByte;
		logic [DATA_W-1:0]   imm;
		logic [PC_W-1:0]     jumpAddr;
	} pmis_req_t;

	// arithmetic status flags
	typedef struct packed {
		logic overflow;
		logic zero;
		logic halfCarry;
		logic carry;
	} pmis_flags_t;

endpackage : pmis_pkg

/* File: design/pmis_watchdog.sv */
`timescale 1ns/1ns
module pmis_watchdog
	import pmis_pkg::*;
(
	input  wire logic               mclk,
	input  wire logic               reset_n,
	input  wire logic               clearAll,
	input  wire logic               enterHalt,
	output logic [WDT_W-1:0]        count_r,
	output logic                    timeout_r,
	output logic                    powerdown_r
);

	logic [PRESC_W-1:0] presc_r;
	logic [PRESC_W-1:0] presc_nxt;
	logic [WDT_W-1:0]   count_nxt;
	logic               timeout_nxt;
	logic               powerdown_nxt;
	logic               prescWrap;
	logic               overflow;

	// prescaler carry advances the counter; counter wrap is a timeout
	assign prescWrap = &presc_r;
	assign overflow  = prescWrap & (&count_r);

	// both clears zero counter and prescaler
	assign presc_nxt = (clearAll | enterHalt) ? PRESC_CLR_VAL :
		PRESC_W'(presc_r + 1'b1); // [RULE10]
	assign count_nxt = (clearAll | enterHalt) ? WDT_CLEAR_VAL :
		prescWrap ? WDT_W'(count_r + 1'b1) : count_r; // [RULE1] [RULE21]

	// an overflow in the clearing cycle still flags, so no timeout is lost
	assign timeout_nxt = overflow ? 1'b1 :
		(clearAll | enterHalt) ? 1'b0 : timeout_r; // [RULE1] [RULE10]
	assign powerdown_nxt = enterHalt ? 1'b1 :
		clearAll ? 1'b0 : powerdown_r; // [RULE10] [RULE21]

	// flag and counter state
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			presc_r     <= PRESC_CLR_VAL;
			count_r     <= WDT_CLEAR_VAL;
			timeout_r   <= 1'b0;
			powerdown_r <= 1'b0;
		end else begin
			presc_r     <= presc_nxt;
			count_r     <= count_nxt;
			timeout_r   <= timeout_nxt;
			powerdown_r <= powerdown_nxt;
		end
	end

endmodule : pmis_watchdog

/* File: test/pmis_mem_model.sv */
`timescale 1ns/1ns
module pmis_mem_model
	import pmis_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              wrEn,
	input  wire logic [DATA_W-1:0] wrAddr,
	input  wire logic [DATA_W-1:0] wrData,
	input  wire logic [DATA_W-1:0] rdAddr,
	output logic      [DATA_W-1:0] rdData
);
	logic [DATA_W-1:0] mem [256];

	// unwritten cells hold a scattered pattern (address xor a5), zero only at address a5
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'ha5;
		end
	end

	// a write lands at the edge that closes the write pulse
	always @(posedge mclk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	// byte read is immediate, like the caller's operand fetch
	assign rdData = mem[rdAddr];
endmodule : pmis_mem_model

/* File: test/tb_top.sv */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
	tests_run++; \
	if ((g) !== (e)) begin \
		error_cnt++; \
		$display("ERROR %s exp %h got %h", nm, e, g); \
	end \
end

module tb_top
	import pmis_pkg::*;
;
	typedef struct packed {
		pmis_op_t    op;
		logic [7:0]  mem;
		logic [7:0]  acc;
		pmis_flags_t fl;
		logic [7:0]  imm;
		logic [7:0]  resA;
		logic [7:0]  resM;
		pmis_flags_t resF;
	} pmis_row_t;

	logic              mclk, reset_n, reqValid, wakeReq, emiClear;
	logic              statusWrEn, reqReady_r, doneStrobe_r, memWrEn_r;
	logic              stackPop_r, emi_r, halted_r, popSeen;
	logic              timeoutFlag_r, powerdownFlag_r;
	pmis_req_t         req;
	pmis_op_t          reqOp;
	pmis_flags_t       statusWrData, flags_r;
	logic [7:0]        reqAddr, reqImm, memByte, memWrAddr_r, memWrData_r;
	logic [7:0]        acc_r, wdtCount_r;
	logic [PC_W-1:0]   stackTop, reqJump, pc_r, pcx;
	int                error_cnt, tests_run, lat;
	pmis_row_t         rows [17];

	// operand byte always comes live from the memory model
	assign req = '{reqOp, reqAddr, memByte, reqImm, reqJump};

	pmis_core i_dut (.mclk(mclk), .reset_n(reset_n), .reqValid(reqValid),
		.req(req), .stackTop(stackTop), .wakeReq(wakeReq),
		.emiClear(emiClear), .statusWrEn(statusWrEn),
		.statusWrData(statusWrData), .reqReady_r(reqReady_r),
		.doneStrobe_r(doneStrobe_r), .memWrEn_r(memWrEn_r),
		.memWrAddr_r(memWrAddr_r), .memWrData_r(memWrData_r),
		.stackPop_r(stackPop_r), .pc_r(pc_r), .acc_r(acc_r),
		.flags_r(flags_r), .emi_r(emi_r), .halted_r(halted_r),
		.wdtCount_r(wdtCount_r), .timeoutFlag_r(timeoutFlag_r),
		.powerdownFlag_r(powerdownFlag_r));

	pmis_mem_model i_mem (.mclk(mclk), .wrEn(memWrEn_r),
		.wrAddr(memWrAddr_r), .wrData(memWrData_r), .rdAddr(reqAddr),
		.rdData(memByte));

	// 25 MHz system clock
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : stop_test

	// one instruction, counting cycles from the taking edge to retire
	task automatic exec(input pmis_op_t op, input logic [7:0] a,
		input logic [7:0] im);
		@(posedge mclk);
		#1;
		reqOp = op;
		reqAddr = a;
		reqImm = im;
		reqValid = 1'b1;
		@(posedge mclk);
		#1;
		reqValid = 1'b0;
		lat = 0;
		while (doneStrobe_r !== 1'b1 && lat < 40) begin
			@(posedge mclk);
			#1;
			lat++;
		end
		popSeen = stackPop_r;
	endtask : exec

	task automatic preset(input pmis_flags_t f);
		@(posedge mclk);
		#1;
		statusWrEn = 1'b1;
		statusWrData = f;
		@(posedge mclk);
		#1;
		statusWrEn = 1'b0;
	endtask : preset

	task automatic wake;
		@(posedge mclk);
		#1;
		wakeReq = 1'b1;
		@(posedge mclk);
		#1;
		wakeReq = 1'b0;
		`CHK("awake", 2'b01, {halted_r, reqReady_r})
	endtask : wake

	// hang guard sized well above the whole sequence
	initial begin
		#(40 * 6000);
		error_cnt++;
		$display("ERROR watchdog run limit exp done got hang");
		stop_test();
	end

	initial begin
		{reqValid, wakeReq, emiClear, statusWrEn} = 4'h0;
		{reqOp, reqAddr, reqImm, reqJump} = '0;
		statusWrData = '0;
		stackTop = 12'h000;
		reset_n = 1'b0;
		// op, mem, acc, flags, imm, acc after, mem after, flags after
		rows[0] = '{OP_COMPLEMENT_MEM, 8'hff, 8'h12, 4'h0,
			8'h00, 8'h12, 8'h00, 4'h4};
		rows[1] = '{OP_COMPLEMENT_TO_ACC, 8'h5a, 8'h00, 4'h5,
			8'h00, 8'ha5, 8'h5a, 4'h1};
		rows[2] = '{OP_DECIMAL_ADJUST, 8'h00, 8'h9b, 4'h4,
			8'h00, 8'h9b, 8'h01, 4'h5};
		rows[3] = '{OP_DECIMAL_ADJUST, 8'h00, 8'h23, 4'h2,
			8'h00, 8'h23, 8'h29, 4'h2};
		rows[4] = '{OP_DECIMAL_ADJUST, 8'h00, 8'h45, 4'h1,
			8'h00, 8'h45, 8'ha5, 4'h1};
		rows[5] = '{OP_DECIMAL_ADJUST, 8'h00, 8'h12, 4'h0,
			8'h00, 8'h12, 8'h12, 4'h0};
		rows[6] = '{OP_INCREMENT_MEM, 8'hff, 8'h11, 4'h0,
			8'h00, 8'h11, 8'h00, 4'h4};
		rows[7] = '{OP_INCREMENT_TO_ACC, 8'h41, 8'h00, 4'h4,
			8'h00, 8'h42, 8'h41, 4'h0};
		rows[8] = '{OP_DECREMENT_MEM, 8'h01, 8'h22, 4'h0,
			8'h00, 8'h22, 8'h00, 4'h4};
		rows[9] = '{OP_DECREMENT_TO_ACC, 8'h00, 8'h33, 4'h4,
			8'h00, 8'hff, 8'h00, 4'h0};
		rows[10] = '{OP_MOVE_MEM_TO_ACC, 8'h3c, 8'h00, 4'hf,
			8'h00, 8'h3c, 8'h3c, 4'hf};
		rows[11] = '{OP_MOVE_IMM_TO_ACC, 8'h10, 8'h00, 4'h0,
			8'h77, 8'h77, 8'h10, 4'h0};
		rows[12] = '{OP_MOVE_ACC_TO_MEM, 8'h10, 8'h81, 4'ha,
			8'h00, 8'h81, 8'h81, 4'ha};
		rows[13] = '{OP_OR_MEM_TO_ACC, 8'h0f, 8'hf0, 4'h4,
			8'h00, 8'hff, 8'h0f, 4'h0};
		rows[14] = '{OP_OR_IMM_TO_ACC, 8'h10, 8'h00, 4'hb,
			8'h00, 8'h00, 8'h10, 4'hf};
		rows[15] = '{OP_OR_TO_MEMORY, 8'h03, 8'h30, 4'h4,
			8'h00, 8'h30, 8'h33, 4'h0};
		rows[16] = '{OP_ROTATE_LEFT_MEM, 8'h81, 8'h00, 4'hf,
			8'h00, 8'h00, 8'h03, 4'hf};
		repeat (3) @(posedge mclk);
		#1;
		reset_n = 1'b1;
		`CHK("reset state", 28'h0000003,
			{pc_r, acc_r, flags_r, emi_r, halted_r, reqReady_r, 1'b1})
		`CHK("reset count", 10'h000, {wdtCount_r, timeoutFlag_r, powerdownFlag_r})
		$display("reset test done");
		// table rows: preload byte and accumulator, preset flags, run
		foreach (rows[i]) begin
			exec(OP_MOVE_IMM_TO_ACC, 8'h20, rows[i].mem);
			exec(OP_MOVE_ACC_TO_MEM, 8'h20, 8'h00);
			exec(OP_MOVE_IMM_TO_ACC, 8'h20, rows[i].acc);
			preset(rows[i].fl);
			pcx = pc_r;
			exec(rows[i].op, 8'h20, rows[i].imm);
			`CHK("acc", rows[i].resA, acc_r)
			`CHK("flags", rows[i].resF, flags_r)
			`CHK("pc", pcx + PC_STEP, pc_r)
			`CHK("cycles", 4, lat)
			@(posedge mclk);
			#1;
			`CHK("mem", rows[i].resM, memByte)
			$display("row %0d done", i);
		end
		// left rotate into the accumulator leaves byte and flags alone
		preset(4'h0);
		exec(OP_ROTATE_LEFT_TO_ACC, 8'h20, 8'h00);
		`CHK("rotate acc", 20'h06003, {acc_r, flags_r, memByte})
		exec(OP_NO_OPERATION, 8'h20, 8'h00);
		`CHK("idle", 20'h06003, {acc_r, flags_r, memByte})
		// jump and the three returns take two instruction cycles
		reqJump = 12'habc;
		exec(OP_JUMP_DIRECT, 8'h20, 8'h00);
		`CHK("jump", {12'habc, 8'd8}, {pc_r, 8'(lat)})
		stackTop = 12'h3a7;
		exec(OP_RETURN_SUBROUTINE, 8'h20, 8'h00);
		`CHK("return", {12'h3a7, 8'd8, 1'b1}, {pc_r, 8'(lat), popSeen})
		stackTop = 12'h1c2;
		exec(OP_RETURN_WITH_VALUE, 8'h20, 8'hc4);
		`CHK("return value", {12'h1c2, 8'hc4, 4'h0}, {pc_r, acc_r, flags_r})
		stackTop = 12'h2f0;
		exec(OP_RETURN_FROM_INT, 8'h20, 8'h00);
		`CHK("int return", {12'h2f0, 1'b1, 1'b1}, {pc_r, emi_r, popSeen})
		// clear only has teeth once the interrupt return has set the bit
		@(posedge mclk);
		#1;
		emiClear = 1'b1;
		@(posedge mclk);
		#1;
		emiClear = 1'b0;
		`CHK("emi off", 1'b0, emi_r)
		$display("branch tests done");
		// writing the program counter low byte costs one extra cycle
		exec(OP_MOVE_IMM_TO_ACC, 8'h20, 8'h9d);
		pcx = pc_r + PC_STEP;
		exec(OP_MOVE_ACC_TO_MEM, 8'h06, 8'h00);
		`CHK("pcl cycles", 8, lat)
		`CHK("pcl pc", {pcx[11:8], 8'h9d}, pc_r)
		// power-down, a refused request, then wake
		pcx = pc_r;
		exec(OP_POWER_DOWN, 8'h20, 8'h00);
		`CHK("halt pc", pcx + PC_STEP, pc_r)
		`CHK("halt state", 12'h006, {wdtCount_r, timeoutFlag_r,
			powerdownFlag_r, halted_r, reqReady_r})
		@(posedge mclk);
		#1;
		reqOp = OP_MOVE_IMM_TO_ACC;
		reqValid = 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		reqValid = 1'b0;
		`CHK("kept acc", 8'h9d, acc_r)
		wake();
		// preclear halves: same half twice is no pair
		repeat (300) @(posedge mclk);
		exec(OP_WDOG_PRECLR_FIRST, 8'h20, 8'h00);
		exec(OP_WDOG_PRECLR_FIRST, 8'h20, 8'h00);
		`CHK("half only", 2'b11, {wdtCount_r != 8'h00, powerdownFlag_r})
		exec(OP_WDOG_PRECLR_SECOND, 8'h20, 8'h00);
		`CHK("pair", 10'h000, {wdtCount_r, timeoutFlag_r, powerdownFlag_r})
		exec(OP_POWER_DOWN, 8'h20, 8'h00);
		wake();
		repeat (300) @(posedge mclk);
		exec(OP_WDOG_PRECLR_SECOND, 8'h20, 8'h00);
		`CHK("fresh pair", 2'b11, {wdtCount_r != 8'h00, powerdownFlag_r})
		exec(OP_WDOG_CLEAR_SINGLE, 8'h20, 8'h00);
		`CHK("single", 10'h000, {wdtCount_r, timeoutFlag_r, powerdownFlag_r})
		$display("watchdog tests done");
		// a reset in mid-run must bring back the reset state
		reset_n = 1'b0;
		repeat (3) @(posedge mclk);
		#1;
		reset_n = 1'b1;
		`CHK("rerun state", 28'h0000003,
			{pc_r, acc_r, flags_r, emi_r, halted_r, reqReady_r, 1'b1})
		`CHK("rerun count", 10'h000, {wdtCount_r, timeoutFlag_r, powerdownFlag_r})
		exec(OP_NO_OPERATION, 8'h20, 8'h00);
		`CHK("rerun nop", {12'h001, 8'd4}, {pc_r, 8'(lat)})
		$display("reset rerun test done");
		stop_test();
	end
endmodule : tb_top
